/* File: core/wfd_defs.svh */
`ifndef WFD_DEFS_SVH
`define WFD_DEFS_SVH

// register byte offsets on the avalon slave
`define WFD_OFS_CTRL_STATUS 6'h00
`define WFD_OFS_IRQ_FLAGS 6'h04
`define WFD_OFS_IRQ_UNMASK 6'h08
`define WFD_OFS_PM_CONTROL 6'h0C
`define WFD_OFS_ADDR_LOW 6'h10
`define WFD_OFS_ADDR_MID 6'h14
`define WFD_OFS_ADDR_HIGH 6'h18
`define WFD_OFS_FILTER_CFG 6'h1C
`define WFD_OFS_MASK_BASE 6'h20
`define WFD_OFS_MASK_LAST 6'h2C
`define WFD_OFS_EXP_CRC 6'h30

// wake_ctrl_status fields
`define WFD_EN_LSB 0
`define WFD_SEEN_LSB 4
`define WFD_CONFIGURED_BIT 8
// phy_irq_flags / phy_irq_unmask field
`define WFD_IRQ_BIT 8
// power_mgmt_control: first phy uses bit 14, second bit 15
`define WFD_PM_WAKE_LSB 14
// pattern_filter_config fields
`define WFD_FLT_EN_BIT 31
`define WFD_FLT_TRIG_BIT 30
`define WFD_FLT_ADDR_CHK_BIT 29
`define WFD_FLT_ANY_MC_BIT 28
`define WFD_FLT_BCAST_BIT 27
`define WFD_OFFSET_W 10

// frame constants
`define WFD_CRC_INIT 16'hFFFF
`define WFD_MASK_BITS 128
`define WFD_DA_LEN 16'h0006
`define WFD_SCAN_START 16'h000C
`define WFD_SYNC_LEN 3'h6
`define WFD_ADDR_BYTES 3'h6
`define WFD_REPEAT_COUNT 5'h10

`endif

/* File: core/wfd_pkg.sv */
package wfd_pkg;

  typedef enum logic {WFD_RX_IDLE, WFD_RX_FRAME} wfd_rx_state_t;

  typedef struct packed {
    logic [2:0] sync_cnt;
    logic in_run;
    logic [2:0] byte_idx;
    logic [4:0] rep_cnt;
    logic found;
  } wfd_rep_state_t;

endpackage

/* File: core/wfd_crc16.sv */
`timescale 1ns/100ps
`default_nettype none

module wfd_crc16 (
  // running value and byte
  input wire logic [15:0] crc,
  input wire logic [7:0] data,
  // updated value
  output logic [15:0] crc_next
);

  logic [7:0] f;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_chain
      if (i == 0) begin : g_first
        assign f[0] = crc[15] ^ data[0];
      end else begin : g_rest
        assign f[i] = crc[15-i] ^ f[i-1] ^ data[i];
      end
    end
    for (i = 2; i < 8; i++) begin : g_low
      assign crc_next[i] = f[7-i] ^ f[9-i];
    end
  endgenerate

  assign crc_next[15] = crc[7] ^ f[7];
  assign crc_next[14:10] = crc[6:2];
  assign crc_next[9] = crc[1] ^ f[0];
  assign crc_next[8] = crc[0] ^ f[1];
  assign crc_next[1] = f[6];
  assign crc_next[0] = f[7];

endmodule

`default_nettype wire

/* File: core/wfd_repeat_det.sv */
`timescale 1ns/100ps
`default_nettype none
`include "wfd_defs.svh"

module wfd_repeat_det (
  input wire logic clock,
  input wire logic rst_n,
  // frame stream
  input wire logic frame_start,
  input wire logic byte_valid,
  input wire logic scan_en,
  input wire logic [7:0] data,
  // programmed address, byte 0 in the low bits
  input wire logic [47:0] wake_addr,
  // sticky until next frame start
  output logic found
);

  wfd_pkg::wfd_rep_state_t s;
  wfd_pkg::wfd_rep_state_t n;
  logic [7:0] exp_byte;
  logic last_byte;

  assign exp_byte = wake_addr[{s.byte_idx, 3'h0} +: 8];
  assign last_byte = (s.byte_idx == `WFD_ADDR_BYTES - 3'h1);
  assign found = s.found;

  always_comb begin
    n = s;
    if (frame_start) begin
      n = '0;
    end else if (byte_valid && scan_en && !s.found) begin
      if (s.in_run) begin
        if (data == exp_byte) begin
          n.byte_idx = last_byte ? 3'h0 : s.byte_idx + 3'h1;
          if (last_byte) begin
            n.rep_cnt = s.rep_cnt + 5'h1;
            n.found = (s.rep_cnt == `WFD_REPEAT_COUNT - 5'h1);
          end
        end else begin
          // broken run: throw progress away and hunt for a new sync stream
          n.in_run = 1'b0;
          n.byte_idx = 3'h0;
          n.rep_cnt = 5'h0;
          n.sync_cnt = (data == 8'hFF) ? 3'h1 : 3'h0;
        end
      end else if (s.sync_cnt == `WFD_SYNC_LEN && data == wake_addr[7:0]) begin
        n.in_run = 1'b1;
        n.byte_idx = 3'h1;
      end else if (data == 8'hFF) begin
        // longer runs of all-ones stay in sync
        n.sync_cnt = (s.sync_cnt == `WFD_SYNC_LEN) ? s.sync_cnt : s.sync_cnt + 3'h1;
      end else begin
        n.sync_cnt = 3'h0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  chk_repeat_sixteen: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(s.found) |-> $past(s.rep_cnt) == 5'hF && $past(s.in_run))
    else $error("repeat match without sixteen copies");

  chk_repeat_break: assert property (@(posedge clock) disable iff (!rst_n)
    (s.in_run && !s.found && byte_valid && scan_en && !frame_start && data != exp_byte)
      |=> !s.in_run && s.rep_cnt == 5'h0)
    else $error("broken run kept its progress");

endmodule

`default_nettype wire

/* File: core/wfd_top.sv */
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "wfd_defs.svh"

module wfd_top #(
  parameter int PHY_INDEX = 0
) (
  input wire logic clock,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // receive stream from the phy datapath
  input wire logic rx_start,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  input wire logic rx_good,
  // wake outputs
  output logic irq_out,
  output logic pm_wake_event,
  output logic combined_wake_indication
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [3:0] en;
    logic [3:0] seen;
    logic configured;
    logic irq_flag;
    logic irq_unmask;
    logic [1:0] pm_wake_en;
    logic [47:0] wake_addr;
    logic flt_en;
    logic flt_trig;
    logic addr_chk;
    logic any_mc;
    logic bc_en;
    logic [`WFD_OFFSET_W-1:0] offset;
    logic [15:0] exp_crc;
    logic [`WFD_MASK_BITS-1:0] mask;
    wfd_pkg::wfd_rx_state_t rx_state;
    logic [15:0] byte_cnt;
    logic da_match;
    logic da_bcast;
    logic da_mcast;
    logic [15:0] crc;
    logic irq_q;
    logic pm_q;
    logic comb_q;
  } wfd_top_state_t;

  wfd_top_state_t s;
  wfd_top_state_t n;

  logic [15:0] crc_upd;
  logic rep_found;
  logic [31:0] img;
  logic [31:0] bmask;
  logic [31:0] wval;
  logic [31:0] clr;
  logic hit;
  logic wr;
  logic [16:0] rel;
  logic sel;
  logic frame_ok;
  logic uni_ok;
  logic mc_ok;
  logic bc_ok;
  logic addr_ok;
  logic [3:0] cand;
  logic [3:0] ev;

  // byte enables widened to a bit mask; shared by merge and clear-on-one
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{be[b]}};
    end
    return m;
  endfunction

  function automatic logic is_mask_word(input logic [5:0] a);
    return (a >= `WFD_OFS_MASK_BASE) && (a <= `WFD_OFS_MASK_LAST);
  endfunction

  wfd_crc16 u_crc (
    .crc(s.crc),
    .data(rx_data),
    .crc_next(crc_upd)
  );

  wfd_repeat_det u_rep (
    .clock(clock),
    .rst_n(rst_n),
    .frame_start(rx_start),
    .byte_valid(rx_valid && s.rx_state == wfd_pkg::WFD_RX_FRAME),
    .scan_en(s.byte_cnt >= `WFD_SCAN_START),
    .data(rx_data),
    .wake_addr(s.wake_addr),
    .found(rep_found)
  );

  // one wait state on every access so read data comes from a flop
  assign hit = (avs_read || avs_write) && !s.ack;
  assign avs_waitrequest = (avs_read || avs_write) && !s.ack;
  assign wr = avs_write && s.ack;
  assign avs_readdata = s.rdata;
  assign irq_out = s.irq_q;
  assign pm_wake_event = s.pm_q;
  assign combined_wake_indication = s.comb_q;

  // register image, also the base for byte-lane merges
  always_comb begin
    img = '0;
    if (avs_address == `WFD_OFS_CTRL_STATUS) begin
      img[`WFD_EN_LSB +: 4] = s.en;
      img[`WFD_SEEN_LSB +: 4] = s.seen;
      img[`WFD_CONFIGURED_BIT] = s.configured;
    end else if (avs_address == `WFD_OFS_IRQ_FLAGS) begin
      img[`WFD_IRQ_BIT] = s.irq_flag;
    end else if (avs_address == `WFD_OFS_IRQ_UNMASK) begin
      img[`WFD_IRQ_BIT] = s.irq_unmask;
    end else if (avs_address == `WFD_OFS_PM_CONTROL) begin
      img[`WFD_PM_WAKE_LSB +: 2] = s.pm_wake_en;
    end else if (avs_address == `WFD_OFS_ADDR_LOW) begin
      img[15:0] = s.wake_addr[15:0];
    end else if (avs_address == `WFD_OFS_ADDR_MID) begin
      img[15:0] = s.wake_addr[31:16];
    end else if (avs_address == `WFD_OFS_ADDR_HIGH) begin
      img[15:0] = s.wake_addr[47:32];
    end else if (avs_address == `WFD_OFS_FILTER_CFG) begin
      img[`WFD_FLT_EN_BIT] = s.flt_en;
      img[`WFD_FLT_TRIG_BIT] = s.flt_trig;
      img[`WFD_FLT_ADDR_CHK_BIT] = s.addr_chk;
      img[`WFD_FLT_ANY_MC_BIT] = s.any_mc;
      img[`WFD_FLT_BCAST_BIT] = s.bc_en;
      img[`WFD_OFFSET_W-1:0] = s.offset;
    end else if (is_mask_word(avs_address)) begin
      img = s.mask[{avs_address[3:2], 5'h00} +: 32];
    end else if (avs_address == `WFD_OFS_EXP_CRC) begin
      img[15:0] = s.exp_crc;
    end
  end

  // pattern byte select: byte (offset + j) with mask bit j
  assign rel = {1'b0, s.byte_cnt} - {7'h00, s.offset};
  assign sel = (s.byte_cnt >= {6'h00, s.offset}) && (rel < 17'h00080)
               && s.mask[rel[6:0]];

  // address classes; broadcast also carries the group bit
  assign uni_ok = !s.da_mcast && (!s.addr_chk || s.da_match);
  assign mc_ok = s.da_mcast && !s.da_bcast
                 && (s.any_mc || (s.addr_chk && s.da_match));
  assign bc_ok = s.da_bcast && s.bc_en;
  assign addr_ok = uni_ok || mc_ok || bc_ok;

  // results are only looked at when the frame has passed its checks
  assign frame_ok = rx_end && rx_good && s.rx_state == wfd_pkg::WFD_RX_FRAME
                    && s.byte_cnt >= `WFD_DA_LEN;
  assign cand[3] = s.da_match;
  assign cand[2] = s.da_bcast;
  assign cand[1] = rep_found && ((s.da_match && !s.da_mcast) || s.da_bcast);
  assign cand[0] = s.flt_en && (s.crc == s.exp_crc) && addr_ok;
  assign ev = {4{frame_ok}} & s.en & cand;

  always_comb begin
    n = s;
    bmask = lane_mask(avs_byteenable);
    wval = (img & ~bmask) | (avs_writedata & bmask);
    clr = avs_writedata & bmask;
    n.ack = hit;
    if (hit && avs_read) begin
      n.rdata = img;
    end
    // bus writes; status bits clear on a written one
    if (wr) begin
      if (avs_address == `WFD_OFS_CTRL_STATUS) begin
        n.en = wval[`WFD_EN_LSB +: 4];
        n.seen = s.seen & ~clr[`WFD_SEEN_LSB +: 4];
        n.configured = wval[`WFD_CONFIGURED_BIT];
      end else if (avs_address == `WFD_OFS_IRQ_FLAGS) begin
        n.irq_flag = s.irq_flag & ~clr[`WFD_IRQ_BIT];
      end else if (avs_address == `WFD_OFS_IRQ_UNMASK) begin
        n.irq_unmask = wval[`WFD_IRQ_BIT];
      end else if (avs_address == `WFD_OFS_PM_CONTROL) begin
        n.pm_wake_en = wval[`WFD_PM_WAKE_LSB +: 2];
      end else if (avs_address == `WFD_OFS_ADDR_LOW) begin
        n.wake_addr[15:0] = wval[15:0];
      end else if (avs_address == `WFD_OFS_ADDR_MID) begin
        n.wake_addr[31:16] = wval[15:0];
      end else if (avs_address == `WFD_OFS_ADDR_HIGH) begin
        n.wake_addr[47:32] = wval[15:0];
      end else if (avs_address == `WFD_OFS_FILTER_CFG) begin
        n.flt_en = wval[`WFD_FLT_EN_BIT];
        n.flt_trig = s.flt_trig & ~clr[`WFD_FLT_TRIG_BIT];
        n.addr_chk = wval[`WFD_FLT_ADDR_CHK_BIT];
        n.any_mc = wval[`WFD_FLT_ANY_MC_BIT];
        n.bc_en = wval[`WFD_FLT_BCAST_BIT];
        n.offset = wval[`WFD_OFFSET_W-1:0];
      end else if (is_mask_word(avs_address)) begin
        n.mask[{avs_address[3:2], 5'h00} +: 32] = wval;
      end else if (avs_address == `WFD_OFS_EXP_CRC) begin
        n.exp_crc = wval[15:0];
      end
    end
    // receive side
    case (s.rx_state)
      wfd_pkg::WFD_RX_IDLE: begin
        if (rx_start) begin
          n.rx_state = wfd_pkg::WFD_RX_FRAME;
        end
      end
      wfd_pkg::WFD_RX_FRAME: begin
        if (rx_end) begin
          n.rx_state = wfd_pkg::WFD_RX_IDLE;
        end else if (rx_valid) begin
          if (s.byte_cnt < `WFD_DA_LEN) begin
            n.da_match = s.da_match
                         && (rx_data == s.wake_addr[{s.byte_cnt[2:0], 3'h0} +: 8]);
            n.da_bcast = s.da_bcast && (rx_data == 8'hFF);
            if (s.byte_cnt == 16'h0000) begin
              n.da_mcast = rx_data[0];
            end
          end
          if (sel) begin
            n.crc = crc_upd;
          end
          if (s.byte_cnt != 16'hFFFF) begin
            n.byte_cnt = s.byte_cnt + 16'h0001;
          end
        end
      end
      default: begin
        n.rx_state = wfd_pkg::WFD_RX_IDLE;
      end
    endcase
    // a start always restarts the frame, also after a frame lost its end
    if (rx_start) begin
      n.rx_state = wfd_pkg::WFD_RX_FRAME;
      n.byte_cnt = '0;
      n.crc = `WFD_CRC_INIT;
      n.da_match = 1'b1;
      n.da_bcast = 1'b1;
      n.da_mcast = 1'b0;
    end
    // hardware sets win over a clear in the same cycle
    n.seen[3:1] = n.seen[3:1] | ev[3:1];
    n.seen[0] = n.seen[0] | ev[0];
    n.flt_trig = n.flt_trig | ev[0];
    n.irq_flag = n.irq_flag | (|ev);
    n.comb_q = |(n.seen & n.en);
    n.irq_q = n.irq_flag && n.irq_unmask;
    n.pm_q = n.comb_q && n.pm_wake_en[PHY_INDEX];
  end

  // only the hard reset clears this state; software resets never reach it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_enable_gates_seen: assert property ($rose(s.seen[3]) |-> $past(s.en[3]))
    else $error("exact seen set while disabled");

  chk_irq_on_event: assert property ((|ev) |=> s.irq_flag ##1 s.irq_flag || wr)
    else $error("wake event did not set irq flag");

  chk_irq_unmasked: assert property ($rose(irq_out) |-> s.irq_unmask && s.irq_flag)
    else $error("irq raised while masked");

  chk_pm_wake_gate: assert property (pm_wake_event |-> s.pm_wake_en[PHY_INDEX])
    else $error("power event without phy wake enable");

  chk_exact_seen: assert property (ev[3] |=> s.seen[3] && s.irq_flag)
    else $error("exact match not recorded");

  chk_bcast_seen: assert property (ev[2] |=> s.seen[2])
    else $error("broadcast match not recorded");

  chk_status_on_end: assert property ((|(s.seen & ~$past(s.seen)))
    |-> $past(rx_end && rx_good))
    else $error("status set outside a good frame end");

  chk_crc_init: assert property (rx_start |=> s.crc == `WFD_CRC_INIT)
    else $error("crc not preset at frame start");

  chk_pattern_crc: assert property ($rose(s.seen[0]) |-> $past(s.crc == s.exp_crc))
    else $error("pattern wake with crc mismatch");

  chk_trig_with_seen: assert property (ev[0] |=> s.flt_trig && s.seen[0])
    else $error("filter triggered not set");

  chk_combined_or: assert property (((s.seen & s.en) != 4'h0) |-> combined_wake_indication)
    else $error("combined indication missing");

  chk_wait_state: assert property ((avs_read && !s.ack) |-> avs_waitrequest ##1 s.ack)
    else $error("wait state not ended");

endmodule

`default_nettype wire

/* File: verification/wfd_station.sv */
`timescale 1ns/100ps
`default_nettype none

module wfd_station (
  // clock
  input wire logic clock,
  // frame stream toward the detector
  output logic rx_start,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic rx_good
);
  initial begin
    rx_start = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
    rx_good = 1'b0;
  end

  // outside a byte the data lines carry junk, so a stale byte never passes
  task automatic send(input logic [7:0] fr[$], input logic good, input int gap);
    @(posedge clock);
    rx_start <= 1'b1;
    @(posedge clock);
    rx_start <= 1'b0;
    foreach (fr[i]) begin
      rx_valid <= 1'b1;
      rx_data <= fr[i];
      @(posedge clock);
      if (gap > 0) begin
        rx_valid <= 1'b0;
        rx_data <= fr[i] + 8'h5B;
        repeat (gap) @(posedge clock);
      end
    end
    rx_valid <= 1'b0;
    rx_data <= rx_data + 8'h5B;
    rx_end <= 1'b1;
    rx_good <= good;
    @(posedge clock);
    rx_end <= 1'b0;
    rx_good <= ~good;
  endtask
endmodule

`default_nettype wire

/* File: verification/wake_frame_detector_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "wfd_defs.svh"

module wake_frame_detector_bench;
  logic clock, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic rx_start, rx_valid, rx_end, rx_good;
  logic irq_out, pm_wake_event, combined_wake_indication;
  logic [7:0] rx_data;
  logic [7:0] fr[$];
  logic [7:0] pl[20];
  logic [31:0] expq[$];
  logic [47:0] addr, src, d;
  logic [127:0] m;
  logic [15:0] crc;
  logic unm, pmb, wk;
  int n_mismatch, n_checks;

  wfd_top #(.PHY_INDEX(0)) u_wfd_top (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_start(rx_start), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
    .rx_good(rx_good), .irq_out(irq_out), .pm_wake_event(pm_wake_event),
    .combined_wake_indication(combined_wake_indication)
  );

  wfd_station u_wfd_station (
    .clock(clock), .rx_start(rx_start), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end), .rx_good(rx_good)
  );

  always #5 clock = ~clock;

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // waitrequest is taken at the rising edge; the request stands until it is seen low there
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] wd, input logic [31:0] exp);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    if (!wr) expq.push_back(exp);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0) begin
      $display("BAD %0t bus access never answered", $time);
      n_mismatch++;
      test_done;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  always @(posedge clock) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (expq.size() == 0) begin
        $display("BAD %0t read answered with no expectation", $time);
        n_mismatch++;
      end else begin
        check(avs_readdata, expq.pop_front());
      end
    end
  end

  function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] b);
    logic [7:0] f;
    logic [15:0] n;
    f[0] = c[15] ^ b[0];
    for (int i = 1; i < 8; i++) f[i] = c[15-i] ^ f[i-1] ^ b[i];
    n[15] = c[7] ^ f[7];
    n[14:10] = c[6:2];
    n[9] = c[1] ^ f[0];
    n[8] = c[0] ^ f[1];
    for (int k = 2; k < 8; k++) n[k] = f[7-k] ^ f[9-k];
    n[1] = f[6];
    n[0] = f[7];
    return n;
  endfunction

  task put(input logic [47:0] a);
    for (int k = 0; k < 6; k++) fr.push_back(a[8*k +: 8]);
  endtask

  task hdr(input logic [47:0] da);
    fr = {};
    put(da);
    put(src);
  endtask

  // seen bits are cleared and enables set fresh before each frame
  task run(input logic [3:0] en, input logic good, input logic [3:0] s);
    bus(1'b1, `WFD_OFS_CTRL_STATUS, {23'h0, 1'b1, 4'hF, en}, 32'h0);
    bus(1'b1, `WFD_OFS_IRQ_FLAGS, 32'h0000_0100, 32'h0);
    u_wfd_station.send(fr, good, $urandom_range(2));
    bus(1'b0, `WFD_OFS_CTRL_STATUS, 32'h0, {23'h0, 1'b1, s, en});
    bus(1'b0, `WFD_OFS_IRQ_FLAGS, 32'h0, {23'h0, |s, 8'h00});
    check({31'h0, irq_out}, {31'h0, |s & unm});
    check({31'h0, pm_wake_event}, {31'h0, |s & pmb});
    check({31'h0, combined_wake_indication}, {31'h0, |s});
  endtask

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    unm = 1'b1;
    pmb = 1'b1;
    n_mismatch = 0;
    n_checks = 0;
    void'($urandom(32'h859C));
    addr = {16'($urandom), $urandom};
    addr[0] = 1'b0;
    src = {16'($urandom), $urandom};
    src[0] = 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    bus(1'b1, 6'h3C, 32'hFFFF_FFFF, 32'h0);
    bus(1'b0, 6'h3C, 32'h0, 32'h0);
    bus(1'b0, `WFD_OFS_CTRL_STATUS, 32'h0, 32'h0);
    bus(1'b0, `WFD_OFS_FILTER_CFG, 32'h0, 32'h0);
    $display("reset test done");
    bus(1'b1, `WFD_OFS_ADDR_LOW, {16'h0, addr[15:0]}, 32'h0);
    bus(1'b1, `WFD_OFS_ADDR_MID, {16'h0, addr[31:16]}, 32'h0);
    bus(1'b1, `WFD_OFS_ADDR_HIGH, {16'h0, addr[47:32]}, 32'h0);
    bus(1'b1, `WFD_OFS_IRQ_UNMASK, 32'h0000_0100, 32'h0);
    bus(1'b1, `WFD_OFS_PM_CONTROL, 32'h0000_4000, 32'h0);
    hdr(addr);
    repeat (10) fr.push_back(8'($urandom));
    run(4'h8, 1'b1, 4'h8);
    run(4'h8, 1'b0, 4'h0);
    run(4'h7, 1'b1, 4'h0);
    hdr(48'hFFFF_FFFF_FFFF);
    repeat (10) fr.push_back(8'($urandom));
    run(4'h4, 1'b1, 4'h4);
    run(4'h8, 1'b1, 4'h0);
    bus(1'b1, `WFD_OFS_IRQ_UNMASK, 32'h0, 32'h0);
    bus(1'b1, `WFD_OFS_PM_CONTROL, 32'h0, 32'h0);
    unm = 1'b0;
    pmb = 1'b0;
    run(4'h4, 1'b1, 4'h4);
    $display("address test done");
    for (int n = 15; n <= 16; n++) begin
      hdr(addr);
      repeat (6) fr.push_back(8'hFF);
      repeat (5) put(addr);
      fr.push_back(~addr[7:0]);
      repeat (6) fr.push_back(8'hFF);
      repeat (n) put(addr);
      run(4'h2, 1'b1, (n == 16) ? 4'h2 : 4'h0);
    end
    $display("repeat test done");
    m = {$urandom, $urandom, $urandom, $urandom};
    m[0] = 1'b1;
    for (int k = 0; k < 4; k++) bus(1'b1, 6'(32'h20 + 4 * k), m[32*k +: 32], 32'h0);
    foreach (pl[i]) pl[i] = 8'($urandom);
    crc = 16'hFFFF;
    for (int j = 0; j < 20; j++) if (m[j]) crc = step(crc, pl[j]);
    bus(1'b1, `WFD_OFS_EXP_CRC, {16'h0, crc}, 32'h0);
    // pass 32 flips one masked byte, so its crc can no longer match
    for (int c = 0; c < 33; c++) begin
      case (c[4:3])
        2'h0: d = addr;
        2'h1: d = addr ^ 48'h0000_0000_8000;
        2'h2: d = addr | 48'h0000_0000_0001;
        default: d = 48'hFFFF_FFFF_FFFF;
      endcase
      wk = (c < 32) && (c[4:3] == 2'h0 || (c[4:3] == 2'h1 && !c[2]) ||
           (c[4:3] == 2'h2 && c[1]) || (c[4:3] == 2'h3 && c[0]));
      bus(1'b1, `WFD_OFS_FILTER_CFG, {2'b11, 3'(c), 17'h0, 10'h00C}, 32'h0);
      hdr(d);
      foreach (pl[i]) fr.push_back(pl[i]);
      if (c == 32) fr[12] = fr[12] ^ 8'h01;
      run(4'h1, 1'b1, {3'h0, wk});
      bus(1'b0, `WFD_OFS_FILTER_CFG, 32'h0, {1'b1, wk, 3'(c), 17'h0, 10'h00C});
    end
    $display("pattern test done");
    test_done;
  end

  initial begin
    #500000;
    n_mismatch++;
    test_done;
  end
endmodule

`default_nettype wire
